/* File: tpwd_pkg.sv */
// Package of constants for the timer, pulse width and divider block
package tpwd_pkg;
   // Register indices on the plain register port
   localparam logic [3:0] REG_CTRL0 = 4'h0;
   localparam logic [3:0] REG_PRE0 = 4'h1;
   localparam logic [3:0] REG_CNT0 = 4'h2;
   localparam logic [3:0] REG_CTRL1 = 4'h3;
   localparam logic [3:0] REG_PRE1L = 4'h4;
   localparam logic [3:0] REG_PRE1H = 4'h5;
   localparam logic [3:0] REG_CNT1L = 4'h6;
   localparam logic [3:0] REG_CNT1H = 4'h7;
   localparam logic [3:0] REG_INTC = 4'h8;
   localparam logic [3:0] REG_PORT = 4'h9;
   localparam logic [3:0] REG_OPT = 4'hA;
   // Control register fields
   localparam int CTRL_MODE_HI = 7;
   localparam int CTRL_MODE_LO = 6;
   localparam int CTRL_SRC = 5;
   localparam int CTRL_RUN = 4;
   localparam int CTRL_EDGE = 3;
   localparam int CTRL_PSC_HI = 2;
   // Interrupt control fields
   localparam int INTC_EN0 = 0;
   localparam int INTC_EN1 = 1;
   localparam int INTC_FLAG0 = 4;
   localparam int INTC_FLAG1 = 5;
   // Port fields: data bit and direction bit of the shared pin
   localparam int PORT_DATA = 3;
   localparam int PORT_DIR = 7;
   // Option fields
   localparam int OPT_DIV_EN = 0;
   localparam int OPT_DIV_SRC = 1;
   localparam int OPT_FILT = 2;
   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] INTC_RST = 8'h00;
   localparam logic [7:0] PORT_RST = 8'h88;
   localparam logic [7:0] OPT_RST = 8'h04;
   // Noise filter length in cycles
   localparam int FILT_CYCLES = 3;
   localparam int SUB_DIV = 4;
   typedef enum logic [1:0]
   {
      TPWD_MODE_NONE = 2'b00,
      TPWD_MODE_EVENT = 2'b01,
      TPWD_MODE_TIMER = 2'b10,
      TPWD_MODE_PULSE = 2'b11
   } tpwd_mode_e;
   typedef enum logic [1:0]
   {
      TPWD_PW_IDLE = 2'b00,
      TPWD_PW_ARMED = 2'b01,
      TPWD_PW_COUNT = 2'b10
   } tpwd_pw_e;
endpackage

/* File: tpwd_input_cond.sv */
// Timer input pin synchroniser, noise filter and edge detector
`timescale 1ns/1ps
module tpwd_input_cond
   import tpwd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic pin,
   input wire logic filt_on,
   output logic level,
   output logic rise,
   output logic fall
);
   logic s1;
   logic s2;
   logic s3;
   logic [1:0] stable;
   logic next_level;
   ////////////////////////////////////////////////////////////////
   // Three stages; s1 only feeds s2
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1 <= 1'b1;
         s2 <= 1'b1;
         s3 <= 1'b1;
      end
      else if (ce)
      begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
      end
   end
   ////////////////////////////////////////////////////////////////
   // Filter wants agreement held for several cycles
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         stable <= 2'h0;
      else if (ce)
      begin
         if (s2 != s3 || s3 == level)
            stable <= 2'h0;
         else if (stable != 2'(FILT_CYCLES - 1))
            stable <= stable + 2'h1;
      end
   end
   always_comb
   begin
      next_level = level;
      if (s2 == s3 && s3 != level)
      begin
         if (!filt_on || stable == 2'(FILT_CYCLES - 1))
            next_level = s3;
      end
   end
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         level <= 1'b1;
         rise <= 1'b0;
         fall <= 1'b0;
      end
      else if (ce)
      begin
         level <= next_level;
         rise <= next_level & ~level;
         fall <= ~next_level & level;
      end
   end
endmodule // tpwd_input_cond

/* File: tpwd_top.sv */
// Two timers with pulse width mode, overflow flags and divider output
`timescale 1ns/1ps
module tpwd_top
   import tpwd_pkg::*;
#(
   parameter int W0 = 8,
   parameter int W1 = 16
)
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic subsidiary_clock,
   input wire logic tmr0_pin,
   input wire logic tmr1_pin,
   input wire logic pull_high_sel,
   input wire logic power_down,
   output logic irq,
   output logic wake,
   input wire logic shared_divider_pin_in,
   output logic shared_divider_pin_out,
   output logic shared_divider_pin_oe,
   output logic tmr0_pull_on,
   output logic tmr1_pull_on
);
   initial
   begin
      if (W0 != 8 || W1 != 16)
         $error("tpwd_top: widths must be 8 and 16");
   end
   logic rst_a;
   logic rst_n;
   logic [7:0] ctrl0;
   logic [7:0] ctrl1;
   logic [7:0] pre0;
   logic [15:0] pre1;
   logic [7:0] pre1l_buf;
   logic [7:0] cnt1l_buf;
   logic [7:0] cnt0;
   logic [15:0] cnt1;
   logic [7:0] intc;
   logic [7:0] port;
   logic [7:0] opt;
   logic [7:0] psc;
   logic [1:0] div4;
   logic [2:0] sub_s;
   logic sub_rise;
   logic tick0;
   logic tick1;
   logic lvl0, rise0, fall0;
   logic lvl1, rise1, fall1;
   logic ev0;
   logic ev1;
   logic ovf0;
   logic ovf1;
   logic hold0;
   logic hold1;
   logic stop0;
   logic stop1;
   logic div_q;
   tpwd_pw_e pw0;
   tpwd_pw_e pw1;
   tpwd_mode_e mode0;
   tpwd_mode_e mode1;
   ////////////////////////////////////////////////////////////////
   // Reset release
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         rst_a <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_a <= 1'b1;
         rst_n <= rst_a;
      end
   end
   assign mode0 = tpwd_mode_e'(ctrl0[CTRL_MODE_HI:CTRL_MODE_LO]);
   assign mode1 = tpwd_mode_e'(ctrl1[CTRL_MODE_HI:CTRL_MODE_LO]);
   ////////////////////////////////////////////////////////////////
   // Input conditioning, one filter option for both pins
   tpwd_input_cond u_in0
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .ce(ce),
      .pin(tmr0_pin),
      .filt_on(opt[OPT_FILT]),
      .level(lvl0),
      .rise(rise0),
      .fall(fall0)
   );
   tpwd_input_cond u_in1
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .ce(ce),
      .pin(tmr1_pin),
      .filt_on(opt[OPT_FILT]),
      .level(lvl1),
      .rise(rise1),
      .fall(fall1)
   );
   ////////////////////////////////////////////////////////////////
   // Clock sources: prescaler, fsys/4, synchronised sub clock
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         psc <= 8'h00;
         div4 <= 2'h0;
         sub_s <= 3'h0;
      end
      else if (ce)
      begin
         psc <= psc + 8'h01;
         div4 <= div4 + 2'h1;
         sub_s <= {sub_s[1:0], subsidiary_clock};
      end
   end
   assign sub_rise = sub_s[1] & ~sub_s[2];
   always_comb
   begin
      // Rate 0 divides by 2, up to 256
      tick0 = 1'b0;
      unique case (ctrl0[CTRL_PSC_HI:0])
         3'h0: tick0 = psc[0:0] == 1'h1;
         3'h1: tick0 = psc[1:0] == 2'h3;
         3'h2: tick0 = psc[2:0] == 3'h7;
         3'h3: tick0 = psc[3:0] == 4'hF;
         3'h4: tick0 = psc[4:0] == 5'h1F;
         3'h5: tick0 = psc[5:0] == 6'h3F;
         3'h6: tick0 = psc[6:0] == 7'h7F;
         3'h7: tick0 = psc == 8'hFF;
      endcase
   end
   assign tick1 = ctrl1[CTRL_SRC] ? sub_rise : (div4 == 2'(SUB_DIV - 1));
   ////////////////////////////////////////////////////////////////
   // Count enables; counter reads and preload writes freeze the clock, for timer 1 only the PRE1H write
   assign hold0 = (rd && addr == REG_CNT0) || (wr && addr == REG_PRE0);
   assign hold1 = (rd && (addr == REG_CNT1H || addr == REG_CNT1L)) || (wr && addr == REG_PRE1H);
   assign ev0 = ctrl0[CTRL_EDGE] ? fall0 : rise0;
   assign ev1 = ctrl1[CTRL_EDGE] ? fall1 : rise1;
   always_comb
   begin
      // Stop follows the pin level every cycle; counting only on the tick gives a small error
      stop0 = (pw0 == TPWD_PW_COUNT) && (ctrl0[CTRL_EDGE] ? lvl0 == 1'b0 : lvl0 == 1'b1);
      stop1 = (pw1 == TPWD_PW_COUNT) && (ctrl1[CTRL_EDGE] ? lvl1 == 1'b0 : lvl1 == 1'b1);
   end
   logic inc0;
   logic inc1;
   always_comb
   begin
      inc0 = 1'b0;
      if (ctrl0[CTRL_RUN] && !hold0)
      begin
         unique case (mode0)
            TPWD_MODE_TIMER: inc0 = tick0;
            TPWD_MODE_EVENT: inc0 = ev0;
            TPWD_MODE_PULSE: inc0 = tick0 && pw0 == TPWD_PW_COUNT && !stop0;
            TPWD_MODE_NONE: inc0 = 1'b0;
         endcase
      end
   end
   always_comb
   begin
      inc1 = 1'b0;
      if (ctrl1[CTRL_RUN] && !hold1)
      begin
         unique case (mode1)
            TPWD_MODE_TIMER: inc1 = tick1;
            TPWD_MODE_EVENT: inc1 = ev1;
            TPWD_MODE_PULSE: inc1 = tick1 && pw1 == TPWD_PW_COUNT && !stop1;
            TPWD_MODE_NONE: inc1 = 1'b0;
         endcase
      end
   end
   assign ovf0 = inc0 && cnt0 == 8'hFF;
   assign ovf1 = inc1 && cnt1 == 16'hFFFF;
   ////////////////////////////////////////////////////////////////
   // Pulse width sequencers
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         pw0 <= TPWD_PW_IDLE;
      else if (ce)
      begin
         unique case (pw0)
            TPWD_PW_IDLE: if (ctrl0[CTRL_RUN] && mode0 == TPWD_MODE_PULSE) pw0 <= TPWD_PW_ARMED;
            TPWD_PW_ARMED:
               if (!ctrl0[CTRL_RUN] || mode0 != TPWD_MODE_PULSE)
                  pw0 <= TPWD_PW_IDLE;
               else if (ctrl0[CTRL_EDGE] ? rise0 : fall0)
                  pw0 <= TPWD_PW_COUNT;
            TPWD_PW_COUNT: if (stop0 || !ctrl0[CTRL_RUN]) pw0 <= TPWD_PW_IDLE;
            default: pw0 <= TPWD_PW_IDLE;
         endcase
      end
   end
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         pw1 <= TPWD_PW_IDLE;
      else if (ce)
      begin
         unique case (pw1)
            TPWD_PW_IDLE: if (ctrl1[CTRL_RUN] && mode1 == TPWD_MODE_PULSE) pw1 <= TPWD_PW_ARMED;
            TPWD_PW_ARMED:
               if (!ctrl1[CTRL_RUN] || mode1 != TPWD_MODE_PULSE)
                  pw1 <= TPWD_PW_IDLE;
               else if (ctrl1[CTRL_EDGE] ? rise1 : fall1)
                  pw1 <= TPWD_PW_COUNT;
            TPWD_PW_COUNT: if (stop1 || !ctrl1[CTRL_RUN]) pw1 <= TPWD_PW_IDLE;
            default: pw1 <= TPWD_PW_IDLE;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////
   // Control registers; hardware clear of run only in pulse mode
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl0 <= CTRL_RST;
         ctrl1 <= CTRL_RST;
      end
      else if (ce)
      begin
         if (wr && addr == REG_CTRL0)
            ctrl0 <= wdata;
         else if (stop0 && mode0 == TPWD_MODE_PULSE)
            ctrl0[CTRL_RUN] <= 1'b0;
         if (wr && addr == REG_CTRL1)
            ctrl1 <= wdata;
         else if (stop1 && mode1 == TPWD_MODE_PULSE)
            ctrl1[CTRL_RUN] <= 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////
   // Preloads and counters; a stopped timer takes preload at once
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pre0 <= 8'h00;
         cnt0 <= 8'h00;
      end
      else if (ce)
      begin
         if (wr && addr == REG_PRE0)
         begin
            pre0 <= wdata;
            if (!ctrl0[CTRL_RUN])
               cnt0 <= wdata;
         end
         else if (ovf0)
            cnt0 <= pre0;
         else if (inc0)
            cnt0 <= cnt0 + 8'h01;
      end
   end
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pre1 <= 16'h0000;
         pre1l_buf <= 8'h00;
         cnt1 <= 16'h0000;
         cnt1l_buf <= 8'h00;
      end
      else if (ce)
      begin
         if (wr && addr == REG_PRE1L)
            pre1l_buf <= wdata;
         if (rd && addr == REG_CNT1H)
            cnt1l_buf <= cnt1[7:0];
         if (wr && addr == REG_PRE1H)
         begin
            pre1 <= {wdata, pre1l_buf};
            if (!ctrl1[CTRL_RUN])
               cnt1 <= {wdata, pre1l_buf};
         end
         else if (ovf1)
            cnt1 <= pre1;
         else if (inc1)
            cnt1 <= cnt1 + 16'h0001;
      end
   end
   ////////////////////////////////////////////////////////////////
   // Flags: hardware set wins over software write
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         intc <= INTC_RST;
      else if (ce)
      begin
         if (wr && addr == REG_INTC)
            intc <= wdata;
         if (ovf0)
            intc[INTC_FLAG0] <= 1'b1;
         if (ovf1)
            intc[INTC_FLAG1] <= 1'b1;
      end
   end
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq <= 1'b0;
         wake <= 1'b0;
      end
      else if (ce)
      begin
         irq <= (intc[INTC_FLAG0] & intc[INTC_EN0]) | (intc[INTC_FLAG1] & intc[INTC_EN1]);
         // A preset flag hides the edge, so no wake
         wake <= power_down && ((ovf0 && !intc[INTC_FLAG0]) || (ovf1 && !intc[INTC_FLAG1]));
      end
   end
   ////////////////////////////////////////////////////////////////
   // Port, option and divider
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         port <= PORT_RST;
         opt <= OPT_RST;
      end
      else if (ce)
      begin
         if (wr && addr == REG_PORT)
            port <= wdata;
         if (wr && addr == REG_OPT)
            opt <= wdata;
      end
   end
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         div_q <= 1'b0;
      else if (ce && (opt[OPT_DIV_SRC] ? ovf1 : ovf0))
         div_q <= ~div_q;
   end
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         shared_divider_pin_out <= 1'b0;
         shared_divider_pin_oe <= 1'b0;
         tmr0_pull_on <= 1'b0;
         tmr1_pull_on <= 1'b0;
      end
      else if (ce)
      begin
         shared_divider_pin_oe <= ~port[PORT_DIR];
         if (opt[OPT_DIV_EN])
            shared_divider_pin_out <= port[PORT_DATA] & div_q;
         else
            shared_divider_pin_out <= port[PORT_DATA];
         tmr0_pull_on <= pull_high_sel;
         tmr1_pull_on <= pull_high_sel;
      end
   end
   ////////////////////////////////////////////////////////////////
   // Read port; data one cycle after strobe, unmapped reads zero
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         rdata <= 8'h00;
      else if (ce)
      begin
         rdata <= 8'h00;
         if (rd)
         begin
            unique case (addr)
               REG_CTRL0: rdata <= ctrl0;
               REG_PRE0: rdata <= pre0;
               REG_CNT0: rdata <= cnt0;
               REG_CTRL1: rdata <= ctrl1;
               REG_PRE1L: rdata <= pre1l_buf;
               REG_PRE1H: rdata <= pre1[15:8];
               REG_CNT1L: rdata <= cnt1l_buf;
               REG_CNT1H: rdata <= cnt1[15:8];
               REG_INTC: rdata <= intc;
               REG_PORT: rdata <= {port[7:4], shared_divider_pin_in, port[2:0]};
               REG_OPT: rdata <= opt;
               default: rdata <= 8'h00;
            endcase
         end
      end
   end
endmodule // tpwd_top

/* File: tpwd_assertions.sv */
// Port-level concurrent checks for the timer block
`timescale 1ns/1ps
module tpwd_assertions
   import tpwd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic pull_high_sel,
   input wire logic power_down,
   input wire logic irq,
   input wire logic wake,
   input wire logic shared_divider_pin_out,
   input wire logic shared_divider_pin_oe,
   input wire logic tmr0_pull_on,
   input wire logic tmr1_pull_on
);
   logic [3:0] live;
   logic dir_sh, data_sh;
   logic [2:0] opt_sh;
   logic [1:0] en_sh;
   ////////////////////////////////////////
   // Shadows of software bits; live waits out the internal reset synchroniser
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         live <= 4'h0;
         dir_sh <= PORT_RST[PORT_DIR];
         data_sh <= PORT_RST[PORT_DATA];
         opt_sh <= OPT_RST[2:0];
         en_sh <= INTC_RST[1:0];
      end
      else
      begin
         live <= {live[2:0], 1'b1};
         if (ce && wr && addr == REG_PORT)
         begin
            dir_sh <= wdata[PORT_DIR];
            data_sh <= wdata[PORT_DATA];
         end
         if (ce && wr && addr == REG_OPT)
            opt_sh <= wdata[2:0];
         if (ce && wr && addr == REG_INTC)
            en_sh <= wdata[1:0];
      end
   end
   ////////////////////////////////////////
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   sequence s_rd(logic [3:0] a);
      live[3] && ce && rd && addr == a;
   endsequence
   a_rdata_idle: assert property (live[3] && !$past(ce && rd) |-> rdata == 8'h00)
      else $error("read data not zero outside answer cycle");
   a_port_readback: assert property (s_rd(REG_PORT) |=> rdata[PORT_DIR] == $past(dir_sh))
      else $error("port direction read back wrong");
   a_opt_readback: assert property (s_rd(REG_OPT) |=> rdata[2:0] == $past(opt_sh))
      else $error("option bits read back wrong");
   a_intc_readback: assert property (s_rd(REG_INTC) |=> rdata[1:0] == $past(en_sh))
      else $error("interrupt enables read back wrong");
   a_oe_follows_dir: assert property (live[3] |-> shared_divider_pin_oe == !$past(dir_sh))
      else $error("divider pin enable disagrees with direction");
   a_pin_forced_low: assert property (live[3] && !$past(data_sh) |-> !shared_divider_pin_out)
      else $error("divider pin high with data bit clear");
   a_pin_plain_port: assert property (live[3] && !$past(opt_sh[OPT_DIV_EN])
      |-> shared_divider_pin_out == $past(data_sh))
      else $error("plain port pin not following data bit");
   a_pull_kept: assert property (live[3] |-> tmr0_pull_on == $past(pull_high_sel)
      && tmr1_pull_on == $past(pull_high_sel))
      else $error("pull-high not following selection");
   a_irq_needs_en: assert property (irq |-> (en_sh | $past(en_sh)) != 2'b00)
      else $error("interrupt raised with enables clear");
   a_wake_needs_pd: assert property (wake |-> power_down || $past(power_down) || $past(power_down, 2))
      else $error("wake without power down");
   a_wake_single: assert property (wake |=> !wake)
      else $error("wake longer than one cycle");
endmodule // tpwd_assertions
bind tpwd_top tpwd_assertions u_chk (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata),
   .wr(wr), .rd(rd), .rdata(rdata), .pull_high_sel(pull_high_sel), .power_down(power_down), .irq(irq),
   .wake(wake), .shared_divider_pin_out(shared_divider_pin_out), .shared_divider_pin_oe(shared_divider_pin_oe),
   .tmr0_pull_on(tmr0_pull_on), .tmr1_pull_on(tmr1_pull_on));

/* File: tpwd_pulse_src.sv */
// Behavioural pulse source on the two timer input pins
`timescale 1ns/1ps
module tpwd_pulse_src
(
   input wire logic clk_sys,
   input wire logic go,
   input wire logic sel,
   input wire logic [7:0] width,
   input wire logic idle0,
   input wire logic idle1,
   output logic pin0,
   output logic pin1
);
   logic [7:0] left = 8'h00;
   logic which = 1'b0;
   ////////////////////////////////////////
   // Whole pulses only; a request while busy is dropped
   always_ff @(posedge clk_sys)
   begin
      if (go && left == 8'h00)
      begin
         left <= width;
         which <= sel;
      end
      else if (left != 8'h00)
         left <= left - 8'h01;
   end
   // A pulse is two transitions, away from idle and back
   assign pin0 = (left != 8'h00 && !which) ? !idle0 : idle0;
   assign pin1 = (left != 8'h00 && which) ? !idle1 : idle1;
endmodule // tpwd_pulse_src

/* File: tpwd_top_tb.sv */
// Self-checking bench for the timer, pulse width and divider block
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin mismatches++; \
   $display("ERROR %s expected %h seen %h", nm, ex, gt); end end
module tpwd_top_tb
   import tpwd_pkg::*;
;
   logic clk_sys = 1'b0, rstn = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0, subsidiary_clock = 1'b0;
   logic [3:0] addr = 4'h0, div_cnt = 4'h0;
   logic [7:0] wdata = 8'h00, rdata, d, d2, pre, pw = 8'h00;
   logic tmr0_pin, tmr1_pin, pull_high_sel = 1'b0, power_down = 1'b0, irq, wake, pin_in = 1'b0;
   logic pin_out, pin_oe, go = 1'b0, psel = 1'b0, idle0 = 1'b1, idle1 = 1'b0, s;
   logic [31:0] seed = 32'h7574945B, seed2 = 32'h7574945B;
   int mismatches = 0, comparisons = 0, cyc = 0, n, w, i;
   ////////////////////////////////////////
   tpwd_top u_dut (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .subsidiary_clock(subsidiary_clock), .tmr0_pin(tmr0_pin), .tmr1_pin(tmr1_pin),
      .pull_high_sel(pull_high_sel), .power_down(power_down), .irq(irq), .wake(wake),
      .shared_divider_pin_in(pin_in), .shared_divider_pin_out(pin_out), .shared_divider_pin_oe(pin_oe),
      .tmr0_pull_on(), .tmr1_pull_on());
   tpwd_pulse_src u_src (.clk_sys(clk_sys), .go(go), .sel(psel), .width(pw), .idle0(idle0), .idle1(idle1),
      .pin0(tmr0_pin), .pin1(tmr1_pin));
   ////////////////////////////////////////
   function logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   // Overflow spacing of timer 0: ticks to wrap times prescale
   function int period(input int psc, input logic [7:0] p);
      return (256 - int'(p)) << (psc + 1);
   endfunction
   task tally_and_finish;
      if (mismatches == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task wr_reg(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask
   task rd_reg(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   // Cycles until the divider pin changes; bounded so a dead pin ends it
   task wait_tgl(output int cnt);
      logic p;
      p = pin_out;
      cnt = 0;
      while (pin_out === p && cnt < 9000)
      begin
         @(posedge clk_sys);
         #1 cnt++;
      end
   endtask
   task wait_flag(input int lim, input logic use_wake, output logic seen);
      seen = 1'b0;
      repeat (lim)
      begin
         @(posedge clk_sys);
         #1 if ((use_wake ? wake : irq) === 1'b1) seen = 1'b1;
      end
   endtask
   task pulse(input logic sl, input int wd);
      @(posedge clk_sys);
      go <= 1'b1;
      psel <= sl;
      pw <= wd[7:0];
      @(posedge clk_sys);
      go <= 1'b0;
      repeat (wd + 30) @(posedge clk_sys);
   endtask
   ////////////////////////////////////////
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys)
   begin
      cyc++;
      seed2 = xs(seed2);
      pull_high_sel <= seed2[0];
      div_cnt <= div_cnt + 4'h1;
      if (div_cnt == 4'hF)
         subsidiary_clock <= ~subsidiary_clock;
      if (cyc == 60000)
      begin
         mismatches++;
         tally_and_finish();
      end
   end
   initial
   begin
      repeat (4) @(posedge clk_sys);
      rstn <= 1'b1;
      pin_in <= seed[9];
      repeat (3) @(posedge clk_sys);
      rd_reg(REG_CTRL0, d);
      `CHK("ctrl0", CTRL_RST, d)
      rd_reg(REG_INTC, d);
      `CHK("intc", INTC_RST, d)
      rd_reg(REG_OPT, d);
      `CHK("opt", OPT_RST[2:0], d[2:0])
      rd_reg(REG_PORT, d);
      `CHK("port", {1'b1, seed[9]}, {d[PORT_DIR], d[PORT_DATA]})
      wr_reg(4'hF, 8'hFF);
      rd_reg(4'hF, d);
      `CHK("unmapped", 8'h00, d)
      // Divider from timer 0 at every prescale rate
      wr_reg(REG_OPT, 8'h05);
      wr_reg(REG_PORT, 8'h08);
      for (i = 0; i < 8; i++)
      begin
         seed = xs(seed);
         pre = {4'hF, seed[3:0]};
         wr_reg(REG_CTRL0, {5'h10, i[2:0]});
         wr_reg(REG_PRE0, pre);
         wr_reg(REG_CTRL0, {5'h12, i[2:0]});
         wait_tgl(n);
         wait_tgl(n);
         `CHK("pfd0", period(i, pre), n)
      end
      rd_reg(REG_CTRL0, d);
      `CHK("run kept", 8'h97, d)
      rd_reg(REG_INTC, d);
      `CHK("flag0", 1'b1, d[INTC_FLAG0])
      `CHK("irq off", 1'b0, irq)
      // Divider from timer 1 while timer 0 keeps running
      wr_reg(REG_CTRL1, 8'h80);
      wr_reg(REG_PRE1L, 8'hF0);
      wr_reg(REG_PRE1H, 8'hFF);
      wr_reg(REG_CTRL1, 8'h90);
      wr_reg(REG_OPT, 8'h07);
      wait_tgl(n);
      wait_tgl(n);
      `CHK("pfd1", 64, n)
      wr_reg(REG_CTRL1, 8'hA0);
      wr_reg(REG_PRE1H, 8'hFF);
      wr_reg(REG_CTRL1, 8'hB0);
      wait_tgl(n);
      wait_tgl(n);
      `CHK("pfd1 sub", 512, n)
      wr_reg(REG_PORT, 8'h00);
      repeat (100) @(posedge clk_sys);
      `CHK("gated", 1'b0, pin_out)
      wr_reg(REG_PORT, 8'h88);
      repeat (3) @(posedge clk_sys);
      `CHK("oe in", 1'b0, pin_oe)
      wr_reg(REG_OPT, 8'h04);
      wr_reg(REG_PORT, 8'h08);
      repeat (3) @(posedge clk_sys);
      `CHK("plain", 2'b11, {pin_oe, pin_out})
      // Interrupt enable, then wake with and without a preset flag
      wr_reg(REG_CTRL1, 8'h80);
      wr_reg(REG_CTRL0, 8'h80);
      wr_reg(REG_PRE0, 8'hF0);
      wr_reg(REG_INTC, 8'h00);
      rd_reg(REG_INTC, d);
      `CHK("flags clr", 2'b00, d[5:4])
      wr_reg(REG_INTC, 8'h01);
      wr_reg(REG_CTRL0, 8'h90);
      wait_flag(100, 1'b0, s);
      `CHK("irq on", 1'b1, s)
      wr_reg(REG_CTRL0, 8'h80);
      wr_reg(REG_INTC, 8'h00);
      @(posedge clk_sys);
      power_down <= 1'b1;
      wr_reg(REG_CTRL0, 8'h90);
      wait_flag(100, 1'b1, s);
      `CHK("wake", 1'b1, s)
      wr_reg(REG_CTRL0, 8'h80);
      wr_reg(REG_INTC, 8'h10);
      wr_reg(REG_CTRL0, 8'h90);
      wait_flag(200, 1'b1, s);
      `CHK("no wake", 1'b0, s)
      wr_reg(REG_CTRL0, 8'h80);
      @(posedge clk_sys);
      power_down <= 1'b0;
      // Pulse mode: a static level must not start the count
      idle0 <= 1'b0;
      // Let the falling level settle before arming
      repeat (10) @(posedge clk_sys);
      wr_reg(REG_PRE0, 8'h00);
      wr_reg(REG_CTRL0, 8'hC0);
      wr_reg(REG_CTRL0, 8'hD0);
      repeat (30) @(posedge clk_sys);
      rd_reg(REG_CNT0, d);
      `CHK("static", 8'h00, d)
      for (i = 0; i < 2; i++)
      begin
         @(posedge clk_sys);
         idle0 <= 1'b1;
         wr_reg(REG_OPT, {5'h00, i[0], 2'b00});
         wr_reg(REG_CTRL0, 8'hC0);
         wr_reg(REG_PRE0, 8'h00);
         wr_reg(REG_CTRL0, 8'hD0);
         seed = xs(seed);
         w = 20 + int'(seed[6:0]);
         pulse(1'b0, w);
         rd_reg(REG_CNT0, d);
         `CHK("pw0", 1'b1, d + 2 >= w / 2 && d <= w / 2 + 2)
         rd_reg(REG_CTRL0, d2);
         `CHK("run clr", 8'hC0, d2)
         pulse(1'b0, 40);
         rd_reg(REG_CNT0, d2);
         `CHK("held", d, d2)
      end
      // Event mode counts rising edges; run stays set
      wr_reg(REG_CTRL0, 8'h40);
      wr_reg(REG_PRE0, 8'h00);
      wr_reg(REG_CTRL0, 8'h50);
      repeat (3) pulse(1'b0, 10);
      rd_reg(REG_CNT0, d);
      `CHK("events", 8'h03, d)
      rd_reg(REG_CTRL0, d);
      `CHK("run ev", 8'h50, d)
      wr_reg(REG_CTRL1, 8'hC8);
      wr_reg(REG_PRE1L, 8'h00);
      wr_reg(REG_PRE1H, 8'h00);
      wr_reg(REG_CTRL1, 8'hD8);
      seed = xs(seed);
      w = 40 + int'(seed[6:0]);
      pulse(1'b1, w);
      rd_reg(REG_CNT1H, d);
      rd_reg(REG_CNT1L, d2);
      `CHK("pw1", 1'b1, {d, d2} + 2 >= w / 4 && {d, d2} <= w / 4 + 2)
      rd_reg(REG_CTRL1, d);
      `CHK("run1 clr", 8'hC8, d)
      tally_and_finish();
   end
endmodule // tpwd_top_tb
